//--- shared/loop_out_pkg.sv
// Purpose: constants shared by the current-loop output mapper and its bench
// Assumes: register words are 32 bits, one aligned word per register
// Notes: currents are held in microamps (1 mA = 1000)
package loop_out_pkg;
	// ************************************************
	// register offsets (byte addresses)
	// ************************************************
	localparam logic [7:0] RANGE_OFS = 8'h00;
	localparam logic [7:0] FUNC_OFS = 8'h04;
	localparam logic [7:0] ALLOC_OFS = 8'h08;
	localparam logic [7:0] MODE_OFS = 8'h0C;
	localparam logic [7:0] MIN_OFS = 8'h10;
	localparam logic [7:0] MAX_OFS = 8'h14;
	localparam logic [7:0] LOW_SP_OFS = 8'h18;
	localparam logic [7:0] HIGH_SP_OFS = 8'h1C;
	localparam logic [7:0] STATUS_OFS = 8'h20;
	// ************************************************
	// field positions
	// ************************************************
	localparam int ALLOC_START_LSB = 0;
	localparam int ALLOC_END_LSB = 8;
	localparam int STATUS_CNT_LSB = 16;
	localparam int STATUS_REJ_BIT = 20;
	// ************************************************
	// codes
	// ************************************************
	localparam logic [2:0] RANGE_OFF = 3'h0;
	localparam logic [2:0] RANGE_0_20 = 3'h1;
	localparam logic [2:0] RANGE_4_20 = 3'h2;
	localparam logic [2:0] RANGE_20_0 = 3'h3;
	localparam logic [2:0] RANGE_20_4 = 3'h4;
	localparam logic [3:0] FUNC_OFF = 4'h0;
	localparam logic [3:0] FUNC_MAX_SMALL = 4'h3;
	localparam logic [3:0] FUNC_LAST_XDCR = 4'h7;
	localparam logic [3:0] FUNC_MA_INPUT = 4'h8;
	localparam logic [3:0] FUNC_COMMS = 4'h9;
	localparam logic [3:0] MODE_DUAL_DIFF = 4'h4;
	localparam logic [3:0] MODE_DUAL_MEAN = 4'h5;
	// ************************************************
	// reset values and currents (microamps)
	// ************************************************
	localparam logic [2:0] RANGE_RESET = RANGE_4_20;
	localparam logic [3:0] FUNC_RESET = 4'h1;
	localparam logic [3:0] ALLOC_START_RESET = 4'h1;
	localparam logic [3:0] ALLOC_END_RESET = 4'h0;
	localparam logic [3:0] MODE_RESET = 4'h1;
	localparam logic signed [15:0] MIN_RESET = 16'sh0ED8;
	localparam logic signed [15:0] MAX_RESET = 16'sh4EE8;
	localparam logic signed [15:0] LOW_SP_RESET = 16'sh0000;
	localparam logic signed [15:0] HIGH_SP_RESET = 16'sh2710;
	localparam logic signed [15:0] UA_ZERO = 16'sh0000;
	localparam logic signed [15:0] UA_4MA = 16'sh0FA0;
	localparam logic signed [15:0] UA_20MA = 16'sh4E20;
endpackage

//--- hdl/current_loop_output_mapper.sv
// Purpose: turn a measured quantity into a 0/4-20 mA drive code with limits
// Assumes: readings come from logic on sys_clk, one update pulse per measurement
// Notes: drive code is in microamps; two combinational divide paths per update, averaging and scaling
`timescale 1ns/1ps
module current_loop_output_mapper
	import loop_out_pkg::*;
#(
	parameter bit LARGE_MODEL = 1'b1,
	parameter bit DUAL_POINT_UNIT = 1'b1,
	parameter int POINTS = 3
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// measurement side
	input wire logic meas_update,
	input wire logic [POINTS*16-1:0] xdcr_value,
	input wire logic [POINTS-1:0] xdcr_in_service,
	input wire logic [POINTS*16-1:0] ma_in_value,
	input wire logic [15:0] comms_value,
	output logic [3:0] quantity_sel,
	// converter side
	output logic [15:0] drive_code,
	output logic drive_enable,
	output logic drive_valid
);
	initial
	begin
		if (POINTS != 3)
			$error("POINTS must be 3");
	end
	// ************************************************
	// configuration registers
	// ************************************************
	logic [2:0] range_sel;
	logic [3:0] func_sel;
	logic [3:0] alloc_start;
	logic [3:0] alloc_end;
	logic [3:0] operation_mode;
	logic signed [15:0] min_limit;
	logic signed [15:0] max_limit;
	logic signed [15:0] low_sp;
	logic signed [15:0] high_sp;
	logic write_rejected;
	logic [1:0] used_count;

	logic wr_range, wr_func, wr_alloc;
	logic func_ok, alloc_ok, alloc_locked;
	logic [3:0] w_start, w_end;
	assign wr_range = reg_wr && reg_addr == RANGE_OFS;
	assign wr_func = reg_wr && reg_addr == FUNC_OFS;
	assign wr_alloc = reg_wr && reg_addr == ALLOC_OFS;
	assign w_start = reg_wdata[ALLOC_START_LSB +: 4];
	assign w_end = reg_wdata[ALLOC_END_LSB +: 4];
	// small model stops at distance, large at comms input
	assign func_ok = LARGE_MODEL ? reg_wdata[3:0] <= FUNC_COMMS : reg_wdata[3:0] <= FUNC_MAX_SMALL;
	// legal: 1, 2, 1:2, and 3 on the large model only
	assign alloc_ok = (w_end == 4'h0 && (w_start == 4'h1 || w_start == 4'h2 || (LARGE_MODEL && w_start == 4'h3)))
		|| (w_start == 4'h1 && w_end == 4'h2);
	assign alloc_locked = !DUAL_POINT_UNIT && func_sel != FUNC_OFF && func_sel <= FUNC_LAST_XDCR
		&& operation_mode != MODE_DUAL_DIFF && operation_mode != MODE_DUAL_MEAN;

	// range code; codes above 4 are refused and the old one kept
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			range_sel <= RANGE_RESET;
		else if (wr_range && reg_wdata[2:0] <= RANGE_20_4 && reg_wdata[31:3] == 29'h0)
			range_sel <= reg_wdata[2:0];
	end

	// function code, model dependent
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			func_sel <= FUNC_RESET;
		else if (wr_func && func_ok)
			func_sel <= reg_wdata[3:0];
	end

	// allocation start and end points
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			alloc_start <= ALLOC_START_RESET;
			alloc_end <= ALLOC_END_RESET;
		end
		else if (wr_alloc && alloc_ok && !alloc_locked)
		begin
			alloc_start <= w_start;
			alloc_end <= w_end;
		end
	end

	// operation mode, limits and setpoints; range writes never touch min_limit
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			operation_mode <= MODE_RESET;
			min_limit <= MIN_RESET;
			max_limit <= MAX_RESET;
			low_sp <= LOW_SP_RESET;
			high_sp <= HIGH_SP_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_addr == MODE_OFS)
				operation_mode <= reg_wdata[3:0];
			if (reg_addr == MIN_OFS)
				min_limit <= reg_wdata[15:0];
			if (reg_addr == MAX_OFS)
				max_limit <= reg_wdata[15:0];
			if (reg_addr == LOW_SP_OFS)
				low_sp <= reg_wdata[15:0];
			if (reg_addr == HIGH_SP_OFS)
				high_sp <= reg_wdata[15:0];
		end
	end

	// sticky refusal flag, cleared by writing status with bit 20 set; a new refusal wins
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			write_rejected <= 1'b0;
		else if ((wr_func && !func_ok) || (wr_alloc && (!alloc_ok || alloc_locked)))
			write_rejected <= 1'b1;
		else if (reg_wr && reg_addr == STATUS_OFS && reg_wdata[STATUS_REJ_BIT])
			write_rejected <= 1'b0;
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || !reg_rd)
			reg_rdata <= 32'h0;
		else
			unique case (reg_addr)
				RANGE_OFS: reg_rdata <= {29'h0, range_sel};
				FUNC_OFS: reg_rdata <= {28'h0, func_sel};
				ALLOC_OFS: reg_rdata <= {20'h0, alloc_end, 4'h0, alloc_start};
				MODE_OFS: reg_rdata <= {28'h0, operation_mode};
				MIN_OFS: reg_rdata <= {16'h0, min_limit};
				MAX_OFS: reg_rdata <= {16'h0, max_limit};
				LOW_SP_OFS: reg_rdata <= {16'h0, low_sp};
				HIGH_SP_OFS: reg_rdata <= {16'h0, high_sp};
				STATUS_OFS: reg_rdata <= {11'h0, write_rejected, 2'h0, used_count, drive_code};
				default: reg_rdata <= 32'h0;
			endcase
	end

	// ************************************************
	// source selection and averaging
	// ************************************************
	logic [3:0] last_point;
	logic signed [17:0] src_sum;
	logic [1:0] src_cnt;
	logic signed [17:0] src_avg;
	// end of zero means start point only
	assign last_point = alloc_end == 4'h0 ? alloc_start : alloc_end;

	always_comb
	begin
		src_sum = 18'sh0;
		src_cnt = 2'h0;
		for (int i = 0; i < POINTS; i++)
		begin
			// current inputs have no service state; transducers may drop out
			if (4'(i + 1) >= alloc_start && 4'(i + 1) <= last_point
				&& (func_sel == FUNC_MA_INPUT || xdcr_in_service[i]))
			begin
				src_sum = src_sum + 18'(signed'(func_sel == FUNC_MA_INPUT ?
					ma_in_value[i*16 +: 16] : xdcr_value[i*16 +: 16]));
				src_cnt = src_cnt + 2'h1;
			end
		end
		if (func_sel == FUNC_COMMS)
		begin
			src_sum = 18'(signed'(comms_value));
			src_cnt = 2'h1;
		end
	end

	// divide by a small constant keeps the mean exact to one count
	always_comb
	begin
		unique case (src_cnt)
			2'h2: src_avg = src_sum / 18'sd2;
			2'h3: src_avg = src_sum / 18'sd3;
			default: src_avg = src_sum;
		endcase
	end

	// ************************************************
	// scaling and clamping
	// ************************************************
	logic signed [15:0] zero_ua;
	logic inverse;
	logic signed [39:0] span, diff, scaled, raw;
	logic signed [15:0] next_code;
	assign zero_ua = (range_sel == RANGE_4_20 || range_sel == RANGE_20_4) ? UA_4MA : UA_ZERO;
	assign inverse = range_sel == RANGE_20_0 || range_sel == RANGE_20_4;
	assign span = 40'(high_sp) - 40'(low_sp);
	assign diff = 40'(src_avg) - 40'(low_sp);

	// wide path so overshoot saturates instead of wrapping
	always_comb
	begin
		if (span == 40'sh0)
			scaled = 40'sh0;
		else
			scaled = diff * (40'(UA_20MA) - 40'(zero_ua)) / span;
		raw = inverse ? 40'(UA_20MA) - scaled : 40'(zero_ua) + scaled;
		if (raw > 40'(max_limit))
			next_code = max_limit;
		else if (raw < 40'(min_limit))
			next_code = min_limit;
		else
			next_code = raw[15:0];
	end

	// output register: refreshed only on a measurement update
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			drive_code <= 16'h0;
			drive_enable <= 1'b0;
			used_count <= 2'h0;
		end
		else if (meas_update)
		begin
			drive_enable <= range_sel != RANGE_OFF && func_sel != FUNC_OFF && src_cnt != 2'h0;
			drive_code <= (range_sel == RANGE_OFF || func_sel == FUNC_OFF) ? 16'h0 :
				src_cnt == 2'h0 ? drive_code : next_code;
			used_count <= src_cnt;
		end
	end

	// update strobe and quantity request
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			drive_valid <= 1'b0;
			quantity_sel <= FUNC_RESET;
		end
		else
		begin
			drive_valid <= meas_update;
			quantity_sel <= func_sel;
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	property p_off_range;
		@(posedge sys_clk) disable iff (!rst_b)
		meas_update && range_sel == RANGE_OFF |=> !drive_enable && drive_code == 16'h0;
	endproperty
	a_off_range: assert property (p_off_range) else $error("off range still drives");
	property p_direct_low_end;
		@(posedge sys_clk) disable iff (!rst_b)
		!inverse && span != 40'sh0 && src_avg == 18'(low_sp) |-> raw == 40'(zero_ua);
	endproperty
	a_direct_low_end: assert property (p_direct_low_end) else $error("direct low end wrong");
	property p_inverse_low_end;
		@(posedge sys_clk) disable iff (!rst_b)
		inverse && span != 40'sh0 && src_avg == 18'(low_sp) |-> raw == 40'(UA_20MA);
	endproperty
	a_inverse_low_end: assert property (p_inverse_low_end) else $error("inverse low end wrong");
	property p_min_kept;
		@(posedge sys_clk) disable iff (!rst_b)
		wr_range |=> $stable(min_limit);
	endproperty
	a_min_kept: assert property (p_min_kept) else $error("range write moved min limit");
	property p_func_refused;
		@(posedge sys_clk) disable iff (!rst_b)
		wr_func && !func_ok |=> $stable(func_sel) && write_rejected;
	endproperty
	a_func_refused: assert property (p_func_refused) else $error("refused function code taken");
	property p_alloc_locked;
		@(posedge sys_clk) disable iff (!rst_b)
		wr_alloc && alloc_locked |=> $stable(alloc_start) && $stable(alloc_end);
	endproperty
	a_alloc_locked: assert property (p_alloc_locked) else $error("locked allocation changed");
	property p_single_point;
		@(posedge sys_clk) disable iff (!rst_b)
		alloc_end == 4'h0 |-> src_cnt <= 2'h1;
	endproperty
	a_single_point: assert property (p_single_point) else $error("single point averaged");
	property p_service_count;
		@(posedge sys_clk) disable iff (!rst_b)
		func_sel <= FUNC_LAST_XDCR |-> src_cnt <= 2'($countones(xdcr_in_service));
	endproperty
	a_service_count: assert property (p_service_count) else $error("dead transducer counted");
	property p_clamp;
		@(posedge sys_clk) disable iff (!rst_b)
		meas_update && (src_cnt != 2'h0 && range_sel != RANGE_OFF
			&& func_sel != FUNC_OFF && min_limit <= max_limit) |=>
			signed'(drive_code) >= min_limit && signed'(drive_code) <= max_limit;
	endproperty
	a_clamp: assert property (p_clamp) else $error("drive code outside limits");
	property p_update_strobe;
		@(posedge sys_clk) disable iff (!rst_b)
		meas_update |=> drive_valid ##1 (drive_valid == $past(meas_update));
	endproperty
	a_update_strobe: assert property (p_update_strobe) else $error("valid not tied to update");
	c_inverse: cover property (@(posedge sys_clk) disable iff (!rst_b) meas_update && inverse && src_cnt != 2'h0);
	c_average: cover property (@(posedge sys_clk) disable iff (!rst_b) meas_update && src_cnt == 2'h2);
	c_clamped: cover property (@(posedge sys_clk) disable iff (!rst_b) meas_update && raw > 40'(max_limit));
endmodule

//--- verification/loop_receiver_model.sv
// Purpose: receiving instrument on the current loop, latching each new drive
// Assumes: drive_valid is a one-cycle pulse on sys_clk
// Notes: a disabled output reads as zero current, like an open loop
`timescale 1ns/1ps
module loop_receiver_model
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// converter side
	input wire logic [15:0] drive_code,
	input wire logic drive_enable,
	input wire logic drive_valid,
	// observed loop current, microamps
	output logic [15:0] loop_ua
);
	// latch only on an update; an old code must not leak through when off
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			loop_ua <= 16'h0000;
		else if (drive_valid)
			loop_ua <= drive_enable ? drive_code : 16'h0000;
	end
endmodule

//--- verification/current_loop_output_mapper_tb.sv
// Purpose: self-checking bench for the current-loop output mapper
// Assumes: low setpoint 0 and high setpoint 10000 stay at reset values
// Notes: expected codes are worked out here from the scaling arithmetic
`timescale 1ns/1ps
module current_loop_output_mapper_tb;
	import loop_out_pkg::*;
	// ************************************************
	// signals
	// ************************************************
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic meas_update = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata;
	logic [47:0] xdcr_value = 48'h000000000000;
	logic [47:0] ma_in_value = 48'h000000000000;
	logic [2:0] xdcr_in_service = 3'h7;
	logic [15:0] comms_value = 16'h0000;
	logic [15:0] drive_code;
	logic [15:0] loop_ua;
	logic [3:0] quantity_sel;
	logic drive_enable;
	logic drive_valid;
	int num_errors = 0;
	int cmp_count = 0;
	// 25 MHz
	always #20 sys_clk = ~sys_clk;
	current_loop_output_mapper #(.LARGE_MODEL(1'b1), .DUAL_POINT_UNIT(1'b1), .POINTS(3)) current_loop_output_mapper_i
	(
		.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_update(meas_update),
		.xdcr_value(xdcr_value), .xdcr_in_service(xdcr_in_service), .ma_in_value(ma_in_value),
		.comms_value(comms_value), .quantity_sel(quantity_sel), .drive_code(drive_code),
		.drive_enable(drive_enable), .drive_valid(drive_valid)
	);
	loop_receiver_model loop_receiver_model_i
	(
		.sys_clk(sys_clk), .rst_b(rst_b), .drive_code(drive_code),
		.drive_enable(drive_enable), .drive_valid(drive_valid), .loop_ua(loop_ua)
	);
	// ************************************************
	// helpers
	// ************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	// one update, then the drive and what the loop receiver saw
	task automatic meas(input logic [15:0] code, input logic en);
		@(posedge sys_clk);
		meas_update <= 1'b1;
		@(posedge sys_clk);
		meas_update <= 1'b0;
		#1 chk(drive_valid, 1'b1);
		chk(drive_enable, en);
		if (en)
			chk(drive_code, code);
		@(posedge sys_clk);
		#1 chk(drive_valid, 1'b0);
		chk(loop_ua, en ? code : 16'h0000);
	endtask
	// direct ranges add the span, inverse ranges subtract it from 20 mA
	function automatic logic [15:0] scale(input logic [2:0] rng, input int avg);
		int zero;
		int s;
		zero = (rng == RANGE_0_20 || rng == RANGE_20_0) ? 0 : 4000;
		s = avg * (20000 - zero) / 10000;
		return (rng <= RANGE_4_20) ? 16'(zero + s) : 16'(20000 - s);
	endfunction
	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset;
		rchk(RANGE_OFS, 32'h00000002);
		rchk(FUNC_OFS, 32'h00000001);
		rchk(ALLOC_OFS, 32'h00000001);
		rchk(MIN_OFS, 32'h00000ED8);
		rchk(MAX_OFS, 32'h00004EE8);
		rchk(HIGH_SP_OFS, 32'h00002710);
		rchk(8'h40, 32'h00000000);
		$display("test reset done");
	endtask
	task automatic t_range;
		xdcr_value <= {16'h0000, 16'h0000, 16'h09C4};
		for (int r = 1; r <= 4; r++)
		begin
			wr(RANGE_OFS, r);
			meas(scale(3'(r), 2500), 1'b1);
		end
		wr(RANGE_OFS, 32'h00000000);
		meas(16'h0000, 1'b0);
		wr(RANGE_OFS, 32'h00000005);
		rchk(RANGE_OFS, 32'h00000000);
		$display("test range done");
	endtask
	task automatic t_min_kept;
		wr(MIN_OFS, 32'h00000FA0);
		wr(RANGE_OFS, 32'h00000003);
		rchk(MIN_OFS, 32'h00000FA0);
		wr(MIN_OFS, 32'h00000ED8);
		$display("test min kept done");
	endtask
	task automatic t_avg;
		logic [31:0] v;
		wr(RANGE_OFS, 32'h00000001);
		xdcr_value <= {16'h2328, 16'h1388, 16'h0BB8};
		wr(ALLOC_OFS, 32'h00000201);
		meas(scale(1, 4000), 1'b1);
		rd(STATUS_OFS, v);
		chk(v[17:16], 2'h2);
		xdcr_in_service <= 3'h5;
		meas(scale(1, 3000), 1'b1);
		xdcr_in_service <= 3'h4;
		meas(16'h0000, 1'b0);
		wr(ALLOC_OFS, 32'h00000003);
		meas(scale(1, 9000), 1'b1);
		xdcr_in_service <= 3'h7;
		wr(ALLOC_OFS, 32'h00000002);
		meas(scale(1, 5000), 1'b1);
		$display("test average done");
	endtask
	task automatic t_func;
		logic [31:0] v;
		ma_in_value <= {16'h0000, 16'h09C4, 16'h0000};
		comms_value <= 16'h1D4C;
		wr(FUNC_OFS, 32'h00000008);
		// the quantity request is a registered copy, one edge behind the function code
		@(posedge sys_clk);
		#1 chk(quantity_sel, 4'h8);
		meas(scale(1, 2500), 1'b1);
		wr(FUNC_OFS, 32'h00000009);
		meas(scale(1, 7500), 1'b1);
		wr(FUNC_OFS, 32'h0000000A);
		rchk(FUNC_OFS, 32'h00000009);
		rd(STATUS_OFS, v);
		chk(v[20], 1'b1);
		wr(STATUS_OFS, 32'h00100000);
		rd(STATUS_OFS, v);
		chk(v[20], 1'b0);
		wr(FUNC_OFS, 32'h00000001);
		$display("test function done");
	endtask
	task automatic t_clamp;
		wr(ALLOC_OFS, 32'h00000001);
		xdcr_value <= {16'h0000, 16'h0000, 16'hF830};
		meas(16'h0ED8, 1'b1);
		xdcr_value <= {16'h0000, 16'h0000, 16'h2EE0};
		meas(16'h4EE8, 1'b1);
		wr(MAX_OFS, 32'h00003A98);
		xdcr_value <= {16'h0000, 16'h0000, 16'h1F40};
		meas(16'h3A98, 1'b1);
		$display("test clamp done");
	endtask
	// ************************************************
	// run control
	// ************************************************
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_range();
		t_min_kept();
		t_avg();
		t_func();
		t_clamp();
		end_sim();
	end
	// tests need well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		end_sim();
	end
endmodule
